// ### common/timer8_pkg.sv
package timer8_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [9:0] CONTROL_A_INDEX = 10'h044;
	localparam logic [9:0] CONTROL_B_INDEX = 10'h045;
	localparam logic [9:0] COUNT_INDEX     = 10'h046;
	localparam logic [9:0] COMPARE_A_INDEX = 10'h047;
	localparam logic [9:0] COMPARE_B_INDEX = 10'h048;
	localparam logic [9:0] IRQ_FLAGS_INDEX = 10'h035;
	localparam logic [9:0] IRQ_MASK_INDEX  = 10'h06e;

	// ------------------------------------------------------------
	// field positions and values
	// ------------------------------------------------------------
	localparam int FORCE_A_BIT   = 7;
	localparam int FORCE_B_BIT   = 6;
	localparam int WAVE_HI_BIT   = 3;
	localparam int FLAG_MATCH_B  = 2;
	localparam int FLAG_MATCH_A  = 1;
	localparam int FLAG_OVERFLOW = 0;
	localparam logic [7:0] COUNT_MAX    = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------
	// prescaler taps: a tap fires when the low bits are all ones
	// ------------------------------------------------------------
	localparam int         PRESCALE_WIDTH = 10;
	localparam logic [9:0] DIV_8_MASK     = 10'h007;
	localparam logic [9:0] DIV_64_MASK    = 10'h03f;
	localparam logic [9:0] DIV_256_MASK   = 10'h0ff;
	localparam logic [9:0] DIV_1024_MASK  = 10'h3ff;

	typedef enum logic [2:0] {
		CLK_STOPPED,
		CLK_DIV_1,
		CLK_DIV_8,
		CLK_DIV_64,
		CLK_DIV_256,
		CLK_DIV_1024,
		CLK_PIN_FALL,
		CLK_PIN_RISE
	} clock_select_type;

	typedef struct packed {
		logic [11:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [11:0] araddr;
		logic        arvalid;
		logic        rready;
	} axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axi_resp_type;

endpackage

// ### src/timer8_ctrl_flags.sv
// How it works
// - force bits act only in non-PWM modes
// - force bit strobes an immediate output match
// - forced match sets no flag, clears nothing
// - force and reserved bits read zero
// - clock select stops, passes or prescales
// - codes 110/111 count pin falling/rising edges
// - count pin counts even when driven
// - counter fully readable and writable
// - counter write blocks next timer-clock match
// - compare A checked continuously against counter
// - compare B checked continuously against counter
// - enable, flag and global bit gate requests
// - flag 2 set on compare B match
// - flag 1 set on compare A match
// - flag 0 set on overflow, mode dependent
// - vector execution clears its flag
// - writing one clears a flag
// - wave mode selects counting and top
// - non-PWM output modes toggle, clear, set
`timescale 1ns/10ps
`default_nettype none

module timer8_ctrl_flags
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire timer8_pkg::axi_req_type  axi_req,
	output timer8_pkg::axi_resp_type      axi_resp,
	input  wire logic                   count_pin,
	input  wire logic                   cpu_irq_enable,
	input  wire logic [2:0]             irq_ack,
	output logic [2:0]                  irq_req,
	output logic                        wave_out_a,
	output logic                        wave_out_b,
	output logic                        wave_oe_a,
	output logic                        wave_oe_b
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  out_mode_a;
		logic [1:0]  out_mode_b;
		logic [1:0]  wave_mode_lo;
		logic        wave_mode_hi;
		logic [2:0]  clock_select;
		logic [7:0]  timer_count;
		logic [7:0]  compare_value_a;
		logic [7:0]  compare_value_b;
		logic [2:0]  timer_irq_mask;
		logic [2:0]  timer_irq_flags;
		logic        count_down;
		logic        block_match;
		logic        wave_a;
		logic        wave_b;
		logic [9:0]  prescale;
		logic        pin_meta;
		logic        pin_sync;
		logic        pin_prev;
		logic        aw_got;
		logic [11:0] aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic        w_lane0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_type;

	state_type state;
	state_type next_state;

	logic        tick;
	logic        match_a;
	logic        match_b;
	logic        ovf_set;
	logic        do_write;
	logic [9:0]  wr_index;
	logic [7:0]  wr_byte;
	logic        wr_count;
	logic        wr_ctrl_b;
	logic        wr_flags;
	logic [2:0]  mode;
	logic        pwm;
	logic        phase;
	logic        fast;
	logic [7:0]  top;
	logic        wrap;
	logic [9:0]  rd_index;
	logic [7:0]  rd_byte;
	logic        rd_hit;
	logic [2:0]  flag_set;

	// ------------------------------------------------------------
	// output compare action
	// ------------------------------------------------------------
	// kind: 0 non-PWM, 1 fast PWM, 2 phase correct
	function automatic logic wave_next(input logic [1:0] omode, input logic cur,
		input logic hit, input logic at_bottom, input logic down,
		input logic toggle_ok, input logic [1:0] kind);
		logic res;
		res = cur;
		if (kind == 2'd0)
		begin
			if (hit)
			begin
				case (omode)
					2'b01:   res = ~cur;
					2'b10:   res = 1'b0;
					2'b11:   res = 1'b1;
					default: res = cur;
				endcase
			end
		end
		else if (omode == 2'b01)
		begin
			if (hit && toggle_ok)
				res = ~cur;
		end
		else if (omode[1])
		begin
			if (kind == 2'd1)
			begin
				if (hit)
					res = omode[0];
				else if (at_bottom)
					res = ~omode[0];
			end
			else if (hit)
				res = omode[0] ^ down;
		end
		return res;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		tick = 1'b0;
		match_a = 1'b0;
		match_b = 1'b0;
		ovf_set = 1'b0;
		wrap = 1'b0;
		flag_set = 3'b000;
		mode = {state.wave_mode_hi, state.wave_mode_lo};
		pwm = state.wave_mode_lo[0];
		phase = (mode == 3'd1) || (mode == 3'd5);
		fast = (mode == 3'd3) || (mode == 3'd7);
		top = ((mode == 3'd2) || (mode == 3'd5) || (mode == 3'd7)) ?
			state.compare_value_a : timer8_pkg::COUNT_MAX;

		// synchroniser and free-running prescaler
		next_state.pin_meta = count_pin;
		next_state.pin_sync = state.pin_meta;
		next_state.pin_prev = state.pin_sync;
		next_state.prescale = state.prescale + 10'h001;

		case (timer8_pkg::clock_select_type'(state.clock_select))
			timer8_pkg::CLK_STOPPED:  tick = 1'b0;
			timer8_pkg::CLK_DIV_1:    tick = 1'b1;
			timer8_pkg::CLK_DIV_8:
				tick = (state.prescale & timer8_pkg::DIV_8_MASK) == timer8_pkg::DIV_8_MASK;
			timer8_pkg::CLK_DIV_64:
				tick = (state.prescale & timer8_pkg::DIV_64_MASK) == timer8_pkg::DIV_64_MASK;
			timer8_pkg::CLK_DIV_256:
				tick = (state.prescale & timer8_pkg::DIV_256_MASK) == timer8_pkg::DIV_256_MASK;
			timer8_pkg::CLK_DIV_1024:
				tick = state.prescale == timer8_pkg::DIV_1024_MASK;
			timer8_pkg::CLK_PIN_FALL: tick = state.pin_prev && !state.pin_sync;
			timer8_pkg::CLK_PIN_RISE: tick = !state.pin_prev && state.pin_sync;
			default:                  tick = 1'b0;
		endcase

		// counting and matching on each timer clock
		if (tick)
		begin
			next_state.block_match = 1'b0;
			match_a = (state.timer_count == state.compare_value_a) && !state.block_match;
			match_b = (state.timer_count == state.compare_value_b) && !state.block_match;
			if (phase)
			begin
				if (state.count_down)
				begin
					if (state.timer_count == timer8_pkg::COUNT_BOTTOM)
					begin
						next_state.count_down = 1'b0;
						next_state.timer_count = state.timer_count + 8'h01;
						ovf_set = 1'b1;
					end
					else
						next_state.timer_count = state.timer_count - 8'h01;
				end
				else if (state.timer_count == top)
				begin
					next_state.count_down = 1'b1;
					next_state.timer_count = state.timer_count - 8'h01;
				end
				else
					next_state.timer_count = state.timer_count + 8'h01;
			end
			else
			begin
				next_state.count_down = 1'b0;
				wrap = state.timer_count == top;
				next_state.timer_count = wrap ? timer8_pkg::COUNT_BOTTOM :
					state.timer_count + 8'h01;
				ovf_set = fast ? wrap : (state.timer_count == timer8_pkg::COUNT_MAX);
			end
			next_state.wave_a = wave_next(state.out_mode_a, state.wave_a, match_a, wrap,
				state.count_down, state.wave_mode_hi, {phase, fast});
			next_state.wave_b = wave_next(state.out_mode_b, state.wave_b, match_b, wrap,
				state.count_down, 1'b0, {phase, fast});
		end
		flag_set = {match_b, match_a, ovf_set};

		// write channel: address and data taken in either order
		do_write = (state.aw_got || axi_req.awvalid) && (state.w_got || axi_req.wvalid)
			&& !state.bvalid;
		wr_index = state.aw_got ? state.aw_addr[11:2] : axi_req.awaddr[11:2];
		wr_byte = state.w_got ? state.w_data[7:0] : axi_req.wdata[7:0];
		wr_count = 1'b0;
		wr_ctrl_b = 1'b0;
		wr_flags = 1'b0;
		if (!state.bvalid && !state.aw_got && axi_req.awvalid)
		begin
			next_state.aw_got = 1'b1;
			next_state.aw_addr = axi_req.awaddr;
		end
		if (!state.bvalid && !state.w_got && axi_req.wvalid)
		begin
			next_state.w_got = 1'b1;
			next_state.w_data = axi_req.wdata;
			next_state.w_lane0 = axi_req.wstrb[0];
		end
		if (do_write)
		begin
			next_state.aw_got = 1'b0;
			next_state.w_got = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = timer8_pkg::RESP_OKAY;
			if (state.w_got ? state.w_lane0 : axi_req.wstrb[0])
			begin
				case (wr_index)
					timer8_pkg::CONTROL_A_INDEX:
					begin
						next_state.out_mode_a = wr_byte[7:6];
						next_state.out_mode_b = wr_byte[5:4];
						next_state.wave_mode_lo = wr_byte[1:0];
					end
					timer8_pkg::CONTROL_B_INDEX:
					begin
						wr_ctrl_b = 1'b1;
						next_state.wave_mode_hi = wr_byte[timer8_pkg::WAVE_HI_BIT];
						next_state.clock_select = wr_byte[2:0];
					end
					timer8_pkg::COUNT_INDEX:     wr_count = 1'b1;
					timer8_pkg::COMPARE_A_INDEX: next_state.compare_value_a = wr_byte;
					timer8_pkg::COMPARE_B_INDEX: next_state.compare_value_b = wr_byte;
					timer8_pkg::IRQ_MASK_INDEX:  next_state.timer_irq_mask = wr_byte[2:0];
					timer8_pkg::IRQ_FLAGS_INDEX: wr_flags = 1'b1;
					default: next_state.bresp = timer8_pkg::RESP_SLVERR;
				endcase
			end
			else if (!(wr_index inside {timer8_pkg::CONTROL_A_INDEX,
				timer8_pkg::CONTROL_B_INDEX, timer8_pkg::COUNT_INDEX,
				timer8_pkg::COMPARE_A_INDEX, timer8_pkg::COMPARE_B_INDEX,
				timer8_pkg::IRQ_MASK_INDEX, timer8_pkg::IRQ_FLAGS_INDEX}))
				next_state.bresp = timer8_pkg::RESP_SLVERR;
		end
		if (state.bvalid && axi_req.bready)
			next_state.bvalid = 1'b0;

		// software counter write wins over the tick and blocks one match
		if (wr_count)
		begin
			next_state.timer_count = wr_byte;
			next_state.block_match = 1'b1;
		end

		// forced match: output only, no flag and no counter clear
		if (wr_ctrl_b && !pwm)
		begin
			if (wr_byte[timer8_pkg::FORCE_A_BIT])
				next_state.wave_a = wave_next(state.out_mode_a, state.wave_a, 1'b1, 1'b0,
					1'b0, 1'b0, 2'd0);
			if (wr_byte[timer8_pkg::FORCE_B_BIT])
				next_state.wave_b = wave_next(state.out_mode_b, state.wave_b, 1'b1, 1'b0,
					1'b0, 1'b0, 2'd0);
		end

		// flags: a hardware set beats a clear in the same cycle
		next_state.timer_irq_flags = (state.timer_irq_flags & ~irq_ack
			& ~(wr_flags ? wr_byte[2:0] : 3'b000)) | flag_set;

		// read channel
		rd_index = axi_req.araddr[11:2];
		rd_hit = 1'b1;
		case (rd_index)
			timer8_pkg::CONTROL_A_INDEX:
				rd_byte = {state.out_mode_a, state.out_mode_b, 2'b00, state.wave_mode_lo};
			timer8_pkg::CONTROL_B_INDEX:
				rd_byte = {4'h0, state.wave_mode_hi, state.clock_select};
			timer8_pkg::COUNT_INDEX:     rd_byte = state.timer_count;
			timer8_pkg::COMPARE_A_INDEX: rd_byte = state.compare_value_a;
			timer8_pkg::COMPARE_B_INDEX: rd_byte = state.compare_value_b;
			timer8_pkg::IRQ_MASK_INDEX:  rd_byte = {5'h00, state.timer_irq_mask};
			timer8_pkg::IRQ_FLAGS_INDEX: rd_byte = {5'h00, state.timer_irq_flags};
			default:
			begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
		if (!state.rvalid && axi_req.arvalid)
		begin
			next_state.rvalid = 1'b1;
			next_state.rdata = {24'h000000, rd_byte};
			next_state.rresp = rd_hit ? timer8_pkg::RESP_OKAY : timer8_pkg::RESP_SLVERR;
		end
		else if (state.rvalid && axi_req.rready)
			next_state.rvalid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= '0;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign axi_resp.awready = !state.bvalid && !state.aw_got;
	assign axi_resp.wready  = !state.bvalid && !state.w_got;
	assign axi_resp.bresp   = state.bresp;
	assign axi_resp.bvalid  = state.bvalid;
	assign axi_resp.arready = !state.rvalid;
	assign axi_resp.rdata   = state.rdata;
	assign axi_resp.rresp   = state.rresp;
	assign axi_resp.rvalid  = state.rvalid;
	assign irq_req    = state.timer_irq_flags & state.timer_irq_mask & {3{cpu_irq_enable}};
	assign wave_out_a = state.wave_a;
	assign wave_out_b = state.wave_b;
	assign wave_oe_a  = state.out_mode_a != 2'b00;
	assign wave_oe_b  = state.out_mode_b != 2'b00;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_count_write;
		wr_count;
	endsequence

	sequence s_tick_no_match;
		tick && !match_a && !match_b;
	endsequence

	AST_CTRL_B_READ_ZERO: assert property (axi_req.arvalid && !state.rvalid &&
		rd_index == timer8_pkg::CONTROL_B_INDEX |=> state.rdata[7:4] == 4'h0)
		else $error("force or reserved bits read nonzero");
	AST_STOPPED_HOLDS: assert property (state.clock_select == 3'd0 && !wr_count
		|=> state.timer_count == $past(state.timer_count))
		else $error("stopped counter moved");
	AST_DIV8_TAP: assert property (tick && state.clock_select == 3'd2
		|-> state.prescale[2:0] == 3'h7)
		else $error("divide by 8 tick off its tap");
	AST_PIN_RISE: assert property (state.clock_select == 3'd7 && tick
		|-> state.pin_sync && !$past(state.pin_sync))
		else $error("rising pin tick without rising edge");
	AST_BLOCK_SET: assert property (s_count_write |=> state.block_match
		&& state.timer_count == $past(wr_byte))
		else $error("counter write did not block the next match");
	AST_BLOCK_CLEAR: assert property (state.block_match && tick |-> s_tick_no_match
		##1 (!state.block_match || $past(wr_count)))
		else $error("blocked tick produced a match");
	AST_FLAG_A_CAUSE: assert property ($rose(state.timer_irq_flags[1])
		|-> $past(tick && state.timer_count == state.compare_value_a && !state.block_match))
		else $error("match A flag set without a match");
	AST_FLAG_B_CAUSE: assert property ($rose(state.timer_irq_flags[2])
		|-> $past(tick && state.timer_count == state.compare_value_b && !state.block_match))
		else $error("match B flag set without a match");
	AST_ACK_CLEARS: assert property (irq_ack[0] && !ovf_set
		|=> !state.timer_irq_flags[0])
		else $error("vector acknowledge left overflow flag set");
	AST_W1C: assert property (wr_flags && wr_byte[1] && !match_a
		|=> !state.timer_irq_flags[1])
		else $error("write one did not clear match A flag");
	AST_FORCE_NO_FLAG: assert property (wr_ctrl_b && wr_byte[7] && !tick
		&& !state.timer_irq_flags[1] |=> !state.timer_irq_flags[1])
		else $error("forced match set a flag");

endmodule

`default_nettype wire

// ### bench/timer8_ctrl_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none

module timer8_ctrl_flags_tb;

	logic                     aclk;
	logic                     aresetn;
	timer8_pkg::axi_req_type  req;
	timer8_pkg::axi_resp_type rsp;
	timer8_pkg::axi_resp_type rsp_s;
	logic                     count_pin;
	logic                     cpu_irq_enable;
	logic [2:0]               irq_ack;
	logic [2:0]               irq_req;
	logic                     wave_out_a;
	logic                     wave_out_b;
	logic                     wave_oe_a;
	logic                     wave_oe_b;
	int                       failures = 0;
	int                       check_count = 0;
	int                       cyc = 0;
	int                       t0;
	int                       n;
	int                       dv [5] = '{1, 8, 64, 256, 1024};
	logic [7:0]               lfsr = 8'h3f;
	logic [31:0]              rdat;
	logic [1:0]               resp;
	logic [7:0]               v;
	logic                     ea = 1'b0;
	logic                     eb = 1'b0;
	logic [9:0]               regs [6] = '{timer8_pkg::CONTROL_B_INDEX, timer8_pkg::COUNT_INDEX,
		timer8_pkg::COMPARE_A_INDEX, timer8_pkg::COMPARE_B_INDEX, timer8_pkg::IRQ_FLAGS_INDEX,
		timer8_pkg::IRQ_MASK_INDEX};

	timer8_ctrl_flags dut_u
	(
		.aclk           (aclk),
		.aresetn        (aresetn),
		.axi_req        (req),
		.axi_resp       (rsp),
		.count_pin      (count_pin),
		.cpu_irq_enable (cpu_irq_enable),
		.irq_ack        (irq_ack),
		.irq_req        (irq_req),
		.wave_out_a     (wave_out_a),
		.wave_out_b     (wave_out_b),
		.wave_oe_a      (wave_oe_a),
		.wave_oe_b      (wave_oe_b)
	);

	// ----------------------------------------------------------
	// clock, cycle count, watchdog
	// ----------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	always @(posedge aclk)
		cyc <= cyc + 1;

	// handshakes are judged on what stood before the edge, not on what the edge launches
	always @(negedge aclk)
		rsp_s = rsp;

	// the whole run needs about 6000 cycles; allow six times that
	initial
	begin
		#(50 * 36000);
		failures++;
		stop_test();
	end

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction

	function automatic logic next_out(input logic [1:0] m, input logic cur);
		case (m)
			2'h1: return ~cur;
			2'h2: return 1'b0;
			2'h3: return 1'b1;
			default: return cur;
		endcase
	endfunction

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// address and data are offered together and each is released once taken
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		req.awaddr <= {i, 2'h0};
		req.wdata <= {24'h000000, d};
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (aw && rsp_s.awready)
			begin
				aw = 1'b0;
				req.awvalid <= 1'b0;
			end
			if (w && rsp_s.wready)
			begin
				w = 1'b0;
				req.wvalid <= 1'b0;
			end
		end
		while (aw || w);
		do @(posedge aclk); while (rsp_s.bvalid !== 1'b1);
		resp = rsp_s.bresp;
	endtask

	task automatic rd(input logic [9:0] i);
		req.araddr <= {i, 2'h0};
		req.arvalid <= 1'b1;
		do @(posedge aclk); while (rsp_s.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (rsp_s.rvalid !== 1'b1);
		rdat = rsp_s.rdata;
		resp = rsp_s.rresp;
	endtask

	task automatic rdc(input logic [9:0] i, input logic [7:0] exp);
		rd(i);
		check($sformatf("reg %h", i), {24'h000000, exp}, rdat);
		check("rresp", timer8_pkg::RESP_OKAY, resp);
	endtask

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial
	begin
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
		count_pin = 1'b0;
		cpu_irq_enable = 1'b0;
		irq_ack = 3'h0;
		aresetn = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (regs[k])
			rdc(regs[k], 8'h00);
		wr(10'h001, 8'h55);
		check("unmapped bresp", timer8_pkg::RESP_SLVERR, resp);
		rd(10'h001);
		check("unmapped rresp", timer8_pkg::RESP_SLVERR, resp);
		// full-width access to counter and compares; mask keeps three bits
		repeat (6)
		begin
			v = rnd();
			wr(timer8_pkg::COUNT_INDEX, v);
			rdc(timer8_pkg::COUNT_INDEX, v);
			wr(timer8_pkg::COMPARE_A_INDEX, ~v);
			rdc(timer8_pkg::COMPARE_A_INDEX, ~v);
			wr(timer8_pkg::COMPARE_B_INDEX, v ^ 8'h5a);
			rdc(timer8_pkg::COMPARE_B_INDEX, v ^ 8'h5a);
			wr(timer8_pkg::IRQ_MASK_INDEX, v);
			rdc(timer8_pkg::IRQ_MASK_INDEX, v & 8'h07);
		end
		wr(timer8_pkg::IRQ_MASK_INDEX, 8'h00);
		wr(timer8_pkg::CONTROL_B_INDEX, 8'hf8);
		rdc(timer8_pkg::CONTROL_B_INDEX, 8'h08);
		// forced matches in clear-on-match mode, counter stopped
		wr(timer8_pkg::CONTROL_B_INDEX, 8'h00);
		wr(timer8_pkg::COUNT_INDEX, 8'h5a);
		for (int m = 1; m < 4; m++)
		begin
			wr(timer8_pkg::CONTROL_A_INDEX, {2'(m), 2'(m), 4'h2});
			check("oe a", 1, wave_oe_a);
			check("oe b", 1, wave_oe_b);
			wr(timer8_pkg::CONTROL_B_INDEX, 8'h80);
			repeat (2) @(posedge aclk);
			ea = next_out(2'(m), ea);
			check("out a", ea, wave_out_a);
			check("out b", eb, wave_out_b);
			wr(timer8_pkg::CONTROL_B_INDEX, 8'h40);
			repeat (2) @(posedge aclk);
			eb = next_out(2'(m), eb);
			check("out b", eb, wave_out_b);
			check("out a", ea, wave_out_a);
		end
		rdc(timer8_pkg::COUNT_INDEX, 8'h5a);
		rdc(timer8_pkg::IRQ_FLAGS_INDEX, 8'h00);
		// in both pwm kinds the strobes are ignored; clear mode would show a forced match
		for (int wm = 1; wm < 4; wm += 2)
		begin
			wr(timer8_pkg::CONTROL_A_INDEX, {6'h28, 2'(wm)});
			wr(timer8_pkg::CONTROL_B_INDEX, 8'hc0);
			repeat (2) @(posedge aclk);
			check("pwm out a", ea, wave_out_a);
			check("pwm out b", eb, wave_out_b);
		end
		wr(timer8_pkg::CONTROL_B_INDEX, 8'h00);
		wr(timer8_pkg::CONTROL_A_INDEX, 8'h00);
		// a full lap of the counter raises all three flags
		wr(timer8_pkg::COMPARE_A_INDEX, rnd());
		wr(timer8_pkg::COMPARE_B_INDEX, rnd());
		wr(timer8_pkg::COUNT_INDEX, 8'h00);
		wr(timer8_pkg::CONTROL_B_INDEX, 8'h01);
		repeat (300) @(posedge aclk);
		wr(timer8_pkg::CONTROL_B_INDEX, 8'h00);
		rdc(timer8_pkg::IRQ_FLAGS_INDEX, 8'h07);
		repeat (8)
		begin
			v = rnd();
			cpu_irq_enable <= v[7];
			wr(timer8_pkg::IRQ_MASK_INDEX, v);
			@(posedge aclk);
			check("irq_req", v[2:0] & {3{v[7]}}, irq_req);
		end
		irq_ack <= 3'h1;
		@(posedge aclk);
		irq_ack <= 3'h0;
		rdc(timer8_pkg::IRQ_FLAGS_INDEX, 8'h06);
		wr(timer8_pkg::IRQ_FLAGS_INDEX, 8'h02);
		rdc(timer8_pkg::IRQ_FLAGS_INDEX, 8'h04);
		wr(timer8_pkg::IRQ_FLAGS_INDEX, 8'h00);
		rdc(timer8_pkg::IRQ_FLAGS_INDEX, 8'h04);
		wr(timer8_pkg::IRQ_FLAGS_INDEX, 8'h04);
		rdc(timer8_pkg::IRQ_FLAGS_INDEX, 8'h00);
		// writing the matching value blocks that match; a lower value does not
		wr(timer8_pkg::COMPARE_A_INDEX, 8'h40);
		wr(timer8_pkg::COMPARE_B_INDEX, 8'h3e);
		wr(timer8_pkg::CONTROL_B_INDEX, 8'h01);
		wr(timer8_pkg::COUNT_INDEX, 8'h40);
		repeat (8) @(posedge aclk);
		wr(timer8_pkg::CONTROL_B_INDEX, 8'h00);
		rdc(timer8_pkg::IRQ_FLAGS_INDEX, 8'h00);
		wr(timer8_pkg::CONTROL_B_INDEX, 8'h01);
		wr(timer8_pkg::COUNT_INDEX, 8'h3c);
		repeat (8) @(posedge aclk);
		wr(timer8_pkg::CONTROL_B_INDEX, 8'h00);
		rdc(timer8_pkg::IRQ_FLAGS_INDEX, 8'h06);
		// prescaler phase is free running, so allow one tick either way
		for (int c = 0; c < 5; c++)
		begin
			wr(timer8_pkg::COUNT_INDEX, 8'h00);
			wr(timer8_pkg::CONTROL_B_INDEX, 8'(c + 1));
			t0 = cyc;
			repeat (4 * dv[c]) @(posedge aclk);
			wr(timer8_pkg::CONTROL_B_INDEX, 8'h00);
			n = (cyc - t0) / dv[c];
			rd(timer8_pkg::COUNT_INDEX);
			check("ticks", 1, (rdat + 1 >= n) && (rdat <= n + 1));
		end
		// pin pulses: n rising edges and n-1 falling edges
		for (int c = 6; c < 8; c++)
		begin
			wr(timer8_pkg::COUNT_INDEX, 8'h00);
			wr(timer8_pkg::CONTROL_B_INDEX, 8'(c));
			n = 3 + (rnd() & 8'h03);
			for (int p = 0; p < n; p++)
			begin
				count_pin <= 1'b1;
				repeat (4) @(posedge aclk);
				if (p < n - 1)
					count_pin <= 1'b0;
				repeat (4) @(posedge aclk);
			end
			wr(timer8_pkg::CONTROL_B_INDEX, 8'h00);
			rdc(timer8_pkg::COUNT_INDEX, 8'(n - ((c == 6) ? 1 : 0)));
			count_pin <= 1'b0;
			repeat (6) @(posedge aclk);
		end
		stop_test();
	end

endmodule

`default_nettype wire
